// ===== rtl/dec_filter_pkg.sv
package dec_filter_pkg;
   // Clock and internal timebase; the timebase is made by a phase accumulator
   localparam int CLK_HZ = 20_000_000;
   localparam int TB_HZ = 12_800_000;
   localparam logic [7:0] TB_INC = 8'(TB_HZ / 100_000);
   localparam logic [7:0] TB_MOD = 8'(CLK_HZ / 100_000);
   // Last prescaler count; 128 timebase ticks per decimation step
   localparam logic [6:0] PRE_LAST = 7'h7F;
   localparam int N_CH = 8;
   localparam int DEC_W = 14;
   localparam int FIFO_DEPTH = 32;
   // Supported decimation factors
   localparam int N_DEC = 58;
   localparam logic [13:0] DEC_TAB [N_DEC] = '{
      14'h0002, 14'h0003, 14'h0004, 14'h0005, 14'h0006, 14'h0007, 14'h0008,
      14'h0009, 14'h000A, 14'h000C, 14'h000E, 14'h0010, 14'h0012, 14'h0014,
      14'h0016, 14'h0018, 14'h001C, 14'h0020, 14'h0024, 14'h0028, 14'h002C,
      14'h0030, 14'h0032, 14'h0038, 14'h0040, 14'h0048, 14'h0050, 14'h0058,
      14'h0060, 14'h0064, 14'h0070, 14'h0080, 14'h0090, 14'h00A0, 14'h00B0,
      14'h00C0, 14'h00C8, 14'h00E0, 14'h00FA, 14'h0100, 14'h0120, 14'h0140,
      14'h0160, 14'h0180, 14'h0190, 14'h01C0, 14'h01F4, 14'h0200, 14'h02C0,
      14'h0320, 14'h03E8, 14'h0400, 14'h0682, 14'h06AA, 14'h07D0, 14'h0800,
      14'h2710, 14'h2800};
   // Factors swapped when the external timebase is 13.1072 MHz
   localparam logic [13:0] D60_STD = 14'h0682;
   localparam logic [13:0] D60_ALT = 14'h06AA;
   localparam logic [13:0] D50_STD = 14'h07D0;
   localparam logic [13:0] D50_ALT = 14'h0800;
   localparam logic [13:0] D10_STD = 14'h2710;
   localparam logic [13:0] D10_ALT = 14'h2800;
   localparam logic [13:0] DECIM_RST = 14'h000A;
   // Register offsets
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_DECIM = 4'h4;
   localparam logic [3:0] A_STAT = 4'h8;
   localparam logic [3:0] A_CNT = 4'hC;
   // Control and status field positions and limits
   localparam int B_EN = 0;
   localparam int B_EXT = 1;
   localparam int B_EXPORT = 2;
   localparam int B_TB13 = 3;
   localparam int B_COMB = 4;
   localparam int B_ORD4 = 5;
   localparam int B_CUT = 8;
   localparam int B_KSEL = 12;
   localparam logic [2:0] CUT_MAX = 3'h5;
   localparam logic [2:0] KSEL_MAX = 3'h4;
   localparam int B_REJ = 0;
   localparam int B_OVR = 1;

   typedef struct packed {
      logic en;
      logic ext;
      logic export_tb;
      logic tb13;
      logic comb;
      logic ord4;
      logic [2:0] cut;
      logic [2:0] ksel;
   } cfg_t;

   localparam cfg_t CFG_RST = '0;

   typedef struct packed {
      logic [N_CH-1:0][15:0] ch;
   } smp_t;

   typedef struct packed {
      logic [2:0] ch;
      logic [31:0] data;
   } res_t;
endpackage

// ===== rtl/dec_filter.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps

// Result buffer with a registered output stage
module res_fifo #(
   parameter int W = 35,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic ov_r, ov_nxt;
   logic [W-1:0] od_r, od_nxt;
   logic push, pop;

   // Pointer and output stage update
   always_comb begin
      push = in_valid && in_ready;
      pop = (cnt_r != '0) && (!ov_r || out_ready);
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
      od_nxt = pop ? mem[rp_r] : od_r;
   end

   assign in_ready = cnt_r != (AW+1)'(DEPTH); // Full stalls the writer

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         ov_r <= 1'b0;
         od_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         ov_r <= ov_nxt;
         od_r <= od_nxt;
      end
   end

   // Storage has no reset, only pointers, count and output stage do
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   assign out_valid = ov_r;
   assign out_data = od_r;
endmodule // res_fifo

// One channel: low-pass cascade and comb averager side by side
module chan_filt (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tick,
   input wire logic last,
   input wire logic flush,
   input wire dec_filter_pkg::cfg_t cfg,
   input wire logic signed [15:0] x,
   output logic [31:0] res
);
   logic signed [23:0] y_r [4];
   logic signed [23:0] y_nxt [4];
   logic signed [23:0] stg_in;
   logic signed [31:0] acc_r, acc_nxt, per, xs;
   logic signed [35:0] tot_r, tot_nxt, old;
   logic [31:0] hist [16];
   logic [3:0] wp_r, wp_nxt;
   logic [4:0] fill_r, fill_nxt, k;
   logic [31:0] res_r, res_nxt;
   logic signed [23:0] y_out;
   logic [5:0] sh;

   // Cut-off counts timebase ticks, so it ignores the decimation
   always_comb begin
      sh = 6'(cfg.cut) + 6'h01;
      for (int i = 0; i < 4; i++) begin
         stg_in = (i == 0) ? {x, 8'h00} : y_r[i-1];
         y_nxt[i] = y_r[i];
         if (flush) begin
            y_nxt[i] = '0;
         end else if (tick) begin
            y_nxt[i] = y_r[i] + ((stg_in - y_r[i]) >>> sh);
         end
      end
   end

   // Comb path: period sum then moving sum of k periods
   always_comb begin
      xs = 32'(x);
      per = acc_r + xs;
      k = 5'h01 << cfg.ksel;
      old = fill_r >= k ? 36'(signed'(hist[wp_r - k[3:0]])) : '0;
      acc_nxt = acc_r;
      tot_nxt = tot_r;
      wp_nxt = wp_r;
      fill_nxt = fill_r;
      if (flush) begin
         acc_nxt = '0;
         tot_nxt = '0;
         wp_nxt = '0;
         fill_nxt = '0;
      end else if (tick) begin
         acc_nxt = last ? '0 : per;
         if (last) begin
            tot_nxt = tot_r + 36'(per) - old;
            wp_nxt = wp_r + 4'h1;
            fill_nxt = (fill_r == 5'h10) ? fill_r : fill_r + 5'h01;
         end
      end
   end

   // Order four costs delay for the steeper roll-off
   always_comb begin
      y_out = cfg.ord4 ? y_nxt[3] : y_nxt[1];
      res_nxt = res_r;
      if (tick && last && !flush) begin
         res_nxt = cfg.comb ? 32'(tot_nxt >>> (6'h07 + 6'(cfg.ksel)))
                            : 32'(y_out >>> 8);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 4; i++) begin
            y_r[i] <= '0;
         end
         acc_r <= '0;
         tot_r <= '0;
         wp_r <= '0;
         fill_r <= '0;
         res_r <= '0;
      end else begin
         y_r <= y_nxt;
         acc_r <= acc_nxt;
         tot_r <= tot_nxt;
         wp_r <= wp_nxt;
         fill_r <= fill_nxt;
         res_r <= res_nxt;
      end
   end

   // History of period sums
   always_ff @(posedge clk) begin
      if (tick && last && !flush) begin
         hist[wp_r] <= per;
      end
   end

   assign res = res_r;
endmodule // chan_filt

// Notes on behaviour
// - Output rate is timebase divided by 128 times the decimation factor.
// - Internal 12.8 MHz timebase is the default source.
// - Decimation factors from 2 up to 10240 per the supported table.
// - Timebase is taken from outside or driven out to other modules.
// - Other external timebase rates scale every data rate in proportion.
// - At 13.1072 MHz, 60/50/10 S/s use factors 1706, 2048, 10240.
// - Filter frequencies scale with the timebase frequency.
// - Module-wide choice between Butterworth and comb response.
// - Butterworth orders two and four, six cut-off settings each.
// - Butterworth cut-off ignores decimation, follows the timebase.
// - Higher order rolls off steeper but delays more.
// - Comb first notch at 1, 1/2, 1/4, 1/8 or 1/16 of data rate.
// - Comb passband follows the selected data rate.
// - Comb at 50 S/s rejects 50 Hz and all harmonics.
// - Every channel has its own path and all sample at one instant.
module dec_filter (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire dec_filter_pkg::smp_t adc_smp,
   input wire logic tb_in,
   output logic tb_out,
   output logic tb_out_oe,
   output logic res_valid,
   input wire logic res_ready,
   output dec_filter_pkg::res_t res_data
);
   dec_filter_pkg::cfg_t cfg_r, cfg_nxt, wcfg;
   logic [13:0] decim_r, decim_nxt, dec_eff;
   logic rej_r, rej_nxt, ovr_r, ovr_nxt;
   logic [31:0] cnt_r, cnt_nxt, rdata_r, rdata_nxt;
   logic flush_r, flush_nxt;
   logic dec_ok, ctrl_ok;
   logic tb_s1_r, tb_s2_r, tb_s3_r, ext_tick;
   logic [7:0] ph_r, ph_nxt;
   logic [8:0] ph_sum;
   logic int_tick_r, int_tick_nxt, tick;
   logic tbo_r, tbo_nxt, oe_r, oe_nxt;
   logic [6:0] pre_r, pre_nxt;
   logic [13:0] dcnt_r, dcnt_nxt;
   logic last;
   logic busy_r, busy_nxt, start_r, start_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic [31:0] res [dec_filter_pkg::N_CH];
   logic f_ready;
   dec_filter_pkg::res_t f_in;

   // Supported-factor lookup
   always_comb begin
      dec_ok = 1'b0;
      for (int i = 0; i < dec_filter_pkg::N_DEC; i++) begin
         if (reg_wdata[13:0] == dec_filter_pkg::DEC_TAB[i]) begin
            dec_ok = 1'b1;
         end
      end
      wcfg.en = reg_wdata[dec_filter_pkg::B_EN];
      wcfg.ext = reg_wdata[dec_filter_pkg::B_EXT];
      wcfg.export_tb = reg_wdata[dec_filter_pkg::B_EXPORT];
      wcfg.tb13 = reg_wdata[dec_filter_pkg::B_TB13];
      wcfg.comb = reg_wdata[dec_filter_pkg::B_COMB];
      wcfg.ord4 = reg_wdata[dec_filter_pkg::B_ORD4];
      wcfg.cut = reg_wdata[dec_filter_pkg::B_CUT +: 3];
      wcfg.ksel = reg_wdata[dec_filter_pkg::B_KSEL +: 3];
      ctrl_ok = wcfg.cut <= dec_filter_pkg::CUT_MAX &&
                wcfg.ksel <= dec_filter_pkg::KSEL_MAX;
   end

   // Register writes, sticky status and read data
   always_comb begin
      cfg_nxt = cfg_r;
      decim_nxt = decim_r;
      rej_nxt = rej_r;
      ovr_nxt = ovr_r;
      flush_nxt = !cfg_r.en;
      rdata_nxt = '0;
      if (reg_rd) begin
         case (reg_addr)
            dec_filter_pkg::A_CTRL: begin
               rdata_nxt[dec_filter_pkg::B_EN] = cfg_r.en;
               rdata_nxt[dec_filter_pkg::B_EXT] = cfg_r.ext;
               rdata_nxt[dec_filter_pkg::B_EXPORT] = cfg_r.export_tb;
               rdata_nxt[dec_filter_pkg::B_TB13] = cfg_r.tb13;
               rdata_nxt[dec_filter_pkg::B_COMB] = cfg_r.comb;
               rdata_nxt[dec_filter_pkg::B_ORD4] = cfg_r.ord4;
               rdata_nxt[dec_filter_pkg::B_CUT +: 3] = cfg_r.cut;
               rdata_nxt[dec_filter_pkg::B_KSEL +: 3] = cfg_r.ksel;
            end
            dec_filter_pkg::A_DECIM: rdata_nxt[13:0] = decim_r;
            dec_filter_pkg::A_STAT: begin
               rdata_nxt[dec_filter_pkg::B_REJ] = rej_r;
               rdata_nxt[dec_filter_pkg::B_OVR] = ovr_r;
               rej_nxt = 1'b0; // Read clears; a set below wins
               ovr_nxt = 1'b0;
            end
            dec_filter_pkg::A_CNT: rdata_nxt = cnt_r;
            default: rdata_nxt = '0;
         endcase
      end
      if (reg_wr && reg_addr == dec_filter_pkg::A_CTRL) begin
         if (ctrl_ok) begin
            cfg_nxt = wcfg;
            flush_nxt = 1'b1; // Restart filters on any change
         end else begin
            rej_nxt = 1'b1;
         end
      end
      if (reg_wr && reg_addr == dec_filter_pkg::A_DECIM) begin
         if (dec_ok) begin
            decim_nxt = reg_wdata[13:0];
            flush_nxt = 1'b1;
         end else begin
            rej_nxt = 1'b1;
         end
      end
      if (last && busy_r) begin
         ovr_nxt = 1'b1; // Buffer could not keep up
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= dec_filter_pkg::CFG_RST;
         decim_r <= dec_filter_pkg::DECIM_RST;
         rej_r <= 1'b0;
         ovr_r <= 1'b0;
         flush_r <= 1'b1;
         rdata_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
         decim_r <= decim_nxt;
         rej_r <= rej_nxt;
         ovr_r <= ovr_nxt;
         flush_r <= flush_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // External timebase pin; every edge is one tick, so it must stay
   // below a quarter of clk to be seen
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tb_s1_r <= 1'b0;
         tb_s2_r <= 1'b0;
         tb_s3_r <= 1'b0;
      end else begin
         tb_s1_r <= tb_in;
         tb_s2_r <= tb_s1_r;
         tb_s3_r <= tb_s2_r;
      end
   end

   assign ext_tick = tb_s2_r ^ tb_s3_r;

   // Internal timebase: average 12.8 MHz tick rate from the 20 MHz clock;
   // the sum is one bit wider so it cannot wrap before the compare
   always_comb begin
      ph_sum = {1'b0, ph_r} + {1'b0, dec_filter_pkg::TB_INC};
      if (ph_sum >= {1'b0, dec_filter_pkg::TB_MOD}) begin
         ph_nxt = 8'(ph_sum - {1'b0, dec_filter_pkg::TB_MOD});
         int_tick_nxt = 1'b1;
      end else begin
         ph_nxt = ph_sum[7:0];
         int_tick_nxt = 1'b0;
      end
      tick = cfg_r.ext ? ext_tick : int_tick_r;
      oe_nxt = cfg_r.export_tb && !cfg_r.ext;
      tbo_nxt = oe_nxt ? tbo_r ^ int_tick_r : 1'b0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_r <= '0;
         int_tick_r <= 1'b0;
         tbo_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt;
         int_tick_r <= int_tick_nxt;
         tbo_r <= tbo_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Decimation divider; the 13.1072 MHz option swaps three factors
   always_comb begin
      case (decim_r)
         dec_filter_pkg::D60_STD: dec_eff = cfg_r.tb13 ?
            dec_filter_pkg::D60_ALT : decim_r;
         dec_filter_pkg::D50_STD: dec_eff = cfg_r.tb13 ?
            dec_filter_pkg::D50_ALT : decim_r;
         dec_filter_pkg::D10_STD: dec_eff = cfg_r.tb13 ?
            dec_filter_pkg::D10_ALT : decim_r;
         default: dec_eff = decim_r;
      endcase
      last = tick && !flush_r && pre_r == dec_filter_pkg::PRE_LAST &&
             dcnt_r == dec_eff - 14'h0001;
      pre_nxt = pre_r;
      dcnt_nxt = dcnt_r;
      if (flush_r) begin
         pre_nxt = '0;
         dcnt_nxt = '0;
      end else if (tick) begin
         pre_nxt = pre_r + 7'h01;
         if (pre_r == dec_filter_pkg::PRE_LAST) begin
            dcnt_nxt = last ? '0 : dcnt_r + 14'h0001;
         end
      end
   end

   // Result serialiser: one word per channel after each output instant
   always_comb begin
      start_nxt = last;
      busy_nxt = busy_r;
      idx_nxt = idx_r;
      cnt_nxt = last ? cnt_r + 32'h0000_0001 : cnt_r;
      if (flush_r) begin
         busy_nxt = 1'b0;
         idx_nxt = '0;
      end else if (start_r && !busy_r) begin
         busy_nxt = 1'b1;
         idx_nxt = '0;
      end else if (busy_r && f_ready) begin
         idx_nxt = idx_r + 3'h1;
         busy_nxt = idx_r != 3'(dec_filter_pkg::N_CH - 1);
      end
      f_in.ch = idx_r;
      f_in.data = res[idx_r];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r <= '0;
         dcnt_r <= '0;
         start_r <= 1'b0;
         busy_r <= 1'b0;
         idx_r <= '0;
         cnt_r <= '0;
      end else begin
         pre_r <= pre_nxt;
         dcnt_r <= dcnt_nxt;
         start_r <= start_nxt;
         busy_r <= busy_nxt;
         idx_r <= idx_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Independent path per channel, all latched on the same strobe
   for (genvar c = 0; c < dec_filter_pkg::N_CH; c++) begin : g_ch
      chan_filt u_chan (
         .clk(clk),
         .arst_n(arst_n),
         .tick(tick),
         .last(last),
         .flush(flush_r),
         .cfg(cfg_r),
         .x(adc_smp.ch[c]),
         .res(res[c])
      );
   end

   res_fifo #(
      .W($bits(dec_filter_pkg::res_t)),
      .DEPTH(dec_filter_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(busy_r),
      .in_ready(f_ready),
      .in_data(f_in),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );

   assign reg_rdata = rdata_r;
   assign tb_out = tbo_r;
   assign tb_out_oe = oe_r;
endmodule // dec_filter

// ===== dv/dec_filter_assertions.sv
`timescale 1ns/1ps

// Port-level checks on the decimation filter
module dec_filter_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire dec_filter_pkg::smp_t adc_smp,
   input wire logic tb_in,
   input wire logic tb_out,
   input wire logic tb_out_oe,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire dec_filter_pkg::res_t res_data
);
   logic [2:0] exp_ch_r;
   logic [2:0] exp_ch_nxt;
   logic stat_rd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Channel due next; a fresh burst may restart at 0 after a flush
   always_comb begin
      exp_ch_nxt = exp_ch_r;
      if (res_valid && res_ready) begin
         exp_ch_nxt = res_data.ch + 3'h1;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         exp_ch_r <= 3'h0;
      end else begin
         exp_ch_r <= exp_ch_nxt;
      end
   end
   assign stat_rd = reg_rd && reg_addr == dec_filter_pkg::A_STAT;

   // Stream order, holding under back-pressure, status and reset
   a_ch_order: assert property (
      res_valid |-> res_data.ch == exp_ch_r || res_data.ch == 3'h0)
      else $error("result channel out of order");
   a_valid_holds: assert property (
      res_valid && !res_ready |=> res_valid)
      else $error("result valid dropped before taken");
   a_data_stable: assert property (
      res_valid && !res_ready |=> $stable(res_data))
      else $error("result word changed before taken");
   a_stat_clear: assert property (
      stat_rd ##1 stat_rd |=> !reg_rdata[dec_filter_pkg::B_REJ])
      else $error("reject flag not cleared by read");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (
      $rose(arst_n) |-> !res_valid && !tb_out_oe && !tb_out)
      else $error("outputs not quiet after reset");
   a_export_runs: assert property (
      tb_out_oe ##1 tb_out_oe |-> ##[0:3] ($changed(tb_out) || !tb_out_oe))
      else $error("exported timebase not toggling");
   a_oe_by_write: assert property (
      $changed(tb_out_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("timebase enable moved without a write");
endmodule // dec_filter_checker

bind dec_filter dec_filter_checker i_dec_filter_checker (
   .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .adc_smp(adc_smp), .tb_in(tb_in),
   .tb_out(tb_out), .tb_out_oe(tb_out_oe), .res_valid(res_valid),
   .res_ready(res_ready), .res_data(res_data)
);

// ===== dv/host_model.sv
`timescale 1ns/1ps

// Host side: shared timebase source and result sink
module host_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ext_run,
   input wire logic stall,
   input wire logic slow,
   output logic tb_in,
   output logic res_ready
);
   logic [2:0] div_r;
   logic odd_r;

   // One timebase for every module; an edge each 5 clocks stays under
   // the clk/4 tracking limit, and it stands still when not running
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 3'h0;
         tb_in <= 1'b0;
      end else if (ext_run) begin
         div_r <= (div_r == 3'h4) ? 3'h0 : div_r + 3'h1;
         if (div_r == 3'h4) begin
            tb_in <= ~tb_in;
         end
      end
   end

   // Sink: prompt, every other cycle when slow, or stalled outright
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         odd_r <= 1'b0;
         res_ready <= 1'b0;
      end else begin
         odd_r <= ~odd_r;
         res_ready <= !stall && !(slow && odd_r);
      end
   end
endmodule // host_model

// ===== dv/dec_filter_tb.sv
`timescale 1ns/1ps

module dec_filter_tb;
   logic clk, arst_n, reg_wr, reg_rd, tb_in, tb_out, tb_out_oe;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic res_valid, res_ready, ext_run, stall, slow;
   dec_filter_pkg::smp_t adc_smp;
   dec_filter_pkg::res_t res_data;
   int err_count, check_count;

   dec_filter i_dec_filter (.clk(clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_smp(adc_smp),
      .tb_in(tb_in), .tb_out(tb_out), .tb_out_oe(tb_out_oe),
      .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
   host_model i_host_model (.clk(clk), .arst_n(arst_n),
      .ext_run(ext_run), .stall(stall), .slow(slow), .tb_in(tb_in),
      .res_ready(res_ready));

   always #25 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Two reads back to back; the second shows what the first left behind
   task automatic rd2(input logic [3:0] a, output logic [31:0] d0,
         output logic [31:0] d1);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      @(posedge clk);
      d0 = reg_rdata;
      reg_rd <= 1'b0;
      @(posedge clk);
      d1 = reg_rdata;
   endtask

   task automatic get_word(output dec_filter_pkg::res_t w);
      for (int i = 0; i < 4000; i++) begin
         @(posedge clk);
         if ((res_valid & res_ready) === 1'b1) begin
            w = res_data;
            return;
         end
      end
      check(32'h0000_0000, 32'h0000_0001);
      print_verdict();
   endtask

   // Words up to and including the next channel 0 word
   task automatic next_inst(output time t, output int n,
         output dec_filter_pkg::res_t w);
      n = 0;
      do begin
         get_word(w);
         n++;
      end while (w.ch !== 3'h0 && n < 64);
      if (w.ch !== 3'h0) begin
         check(32'(w.ch), 32'h0000_0000);
         print_verdict();
      end
      t = $time;
   endtask

   // Disable, set the factor, let old words drain, then start afresh
   task automatic cfg(input logic [31:0] c, input logic [31:0] d);
      wr(4'h0, 32'h0000_0000);
      wr(4'h4, d);
      repeat (20) @(posedge clk);
      for (int i = 0; i < 100 && res_valid !== 1'b0; i++) begin
         @(posedge clk);
      end
      if (res_valid !== 1'b0) begin
         check(32'(res_valid), 32'h0000_0000);
         print_verdict();
      end
      wr(4'h0, c);
   endtask

   task automatic t_regs();
      logic [31:0] a, b;
      rd2(4'h0, a, b);
      check(a, 32'h0000_0000);
      rd2(4'h4, a, b);
      check(a, 32'(dec_filter_pkg::DECIM_RST));
      rd2(4'hC, a, b);
      check(a, 32'h0000_0000);
      rd2(4'h2, a, b);
      check(a, 32'h0000_0000);
   endtask

   task automatic t_decim();
      logic [31:0] a, b;
      logic [13:0] bad [5] = '{14'h0000, 14'h0001, 14'h000B, 14'h2711,
         14'h3FFF};
      for (int i = 0; i < dec_filter_pkg::N_DEC; i++) begin
         wr(4'h4, 32'(dec_filter_pkg::DEC_TAB[i]));
         rd2(4'h4, a, b);
         check(a, 32'(dec_filter_pkg::DEC_TAB[i]));
      end
      // Factors outside the table leave the last good one in place
      foreach (bad[i]) begin
         wr(4'h4, 32'(bad[i]));
         rd2(4'h4, a, b);
         check(a, 32'(dec_filter_pkg::D10_ALT));
         rd2(4'h8, a, b);
         check(32'(a[0]), 32'h0000_0001);
         check(32'(b[0]), 32'h0000_0000);
      end
   endtask

   task automatic t_ctrl();
      logic [31:0] a, b, v;
      // Both orders with six cut-offs each, then five notch settings
      for (int m = 0; m < 17; m++) begin
         v = m < 12 ? 32'((m / 6) << 5 | (m % 6) << 8)
            : 32'((m - 12) << 12 | 16);
         wr(4'h0, v);
         rd2(4'h0, a, b);
         check(a, v);
      end
      wr(4'h0, 32'h0000_0600);
      wr(4'h0, 32'h0000_5010);
      rd2(4'h0, a, b);
      check(a, 32'h0000_4010);
      rd2(4'h8, a, b);
      check(32'(a[0]), 32'h0000_0001);
      wr(4'h0, 32'h0000_000E);
      rd2(4'h0, a, b);
      check(a, 32'h0000_000E);
   endtask

   // Spacing of output instants against the expected count of clocks
   task automatic t_rate(input logic [31:0] c, input int per,
         input logic oe);
      time t0, t1, t2;
      int n, m, d;
      logic [31:0] c0, c1, x;
      dec_filter_pkg::res_t w;
      cfg(c, 32'h0000_0002);
      // Count a whole burst first; a register read would skip words
      next_inst(t0, n, w);
      next_inst(t1, n, w);
      rd2(4'hC, c0, x);
      next_inst(t2, m, w);
      rd2(4'hC, c1, x);
      d = int'((t1 - t0) / 50);
      check(32'(n), 32'h0000_0008);
      check(32'(d >= per - 3 && d <= per + 3), 32'h0000_0001);
      check(c1 - c0, 32'h0000_0001);
      check(32'(tb_out_oe), 32'(oe));
   endtask

   // Settled comb output equals the factor times the constant input
   task automatic t_comb(input int a, input int sel);
      time t;
      int n;
      dec_filter_pkg::res_t w;
      cfg(32'(sel << 12 | 17), 32'(a));
      repeat ((1 << sel) + 2) next_inst(t, n, w);
      for (int c = 0; c < 8; c++) begin
         if (c > 0) begin
            get_word(w);
         end
         check(w.data, 32'(a * (c * 700 - 2000)));
      end
   endtask

   // Stall the sink until the buffer refuses and instants are lost
   task automatic t_ovf();
      logic [31:0] a, b;
      cfg(32'h0000_0001, 32'h0000_0002);
      stall <= 1'b1;
      repeat (3600) @(posedge clk);
      check(32'(res_valid), 32'h0000_0001);
      rd2(4'h8, a, b);
      check(32'(a[1]), 32'h0000_0001);
      stall <= 1'b0;
      repeat (100) @(posedge clk);
      rd2(4'h8, a, b);
      check(b, 32'h0000_0000);
   endtask

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      ext_run = 1'b0;
      stall = 1'b0;
      slow = 1'b0;
      for (int c = 0; c < 8; c++) begin
         adc_smp.ch[c] = 16'(c * 700 - 2000);
      end
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_decim();
      t_ctrl();
      t_rate(32'h0000_0005, 400, 1'b1);
      ext_run <= 1'b1;
      slow <= 1'b1;
      t_rate(32'h0000_0007, 1280, 1'b0);
      ext_run <= 1'b0;
      slow <= 1'b0;
      for (int s = 0; s < 5; s++) begin
         t_comb(2, s);
      end
      t_comb(3, 0);
      t_ovf();
      print_verdict();
   end
endmodule // dec_filter_tb
